// ===== rtl/swa_ctrl.sv
// Control logic for a 32-channel switch array with serial shift register and latches.
// Assumes the serial pins arrive on link_clk; mode, sleep and wipe are pins on clk.
`timescale 1ns/1ps
// Behaviour
// - In individual mode each switch follows its own latch bit.
// - Serial input is sampled on every rising serial clock edge in individual mode while awake, except the edge that clears on mode rise.
// - Rising latch strobe freezes latches until the strobe falls again.
// - Strobe low makes latches transparent to the shift register.
// - Serial output shows shift register stage 31 in individual mode.
// - With strobe high, shifting leaves switch states unchanged.
// - In individual mode, latch wipe high forces all switches off, overriding strobe and data.
// - Shared strobe is latch enable low, or bank enable high in bank mode.
// - Mode low selects bank operation, mode high individual operation.
// - Bank enabled: select pin picks even or odd switches; wipe, clock ignored.
// - Sleep low forces all switches off and overrides every other input except ce, which freezes the outputs while low.
// - Bank select high closes even switches, low closes odd switches.
// - Bank enable low turns every switch off.
// - Controller shifts bit for switch 31 first and switch 0 last.
// - Mode rising clears the shift register; wipe never touches it.
module swa_ctrl
    import swa_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic sleep_n,
    input wire logic mode,
    input wire logic serial_in_or_bank_select,
    input wire logic latch_strobe_or_bank_enable,
    input wire logic latch_wipe,
    output logic [31:0] switch_on,
    output logic serial_out,
    output logic serial_out_oe,
    output logic fifo_overflow
);
    // Link domain: shift register clocked by the serial clock.
    typedef struct packed {
        logic [31:0] shreg;
        logic [1:0] mode_sync;
        logic mode_prev;
        logic sleep_s1;
        logic sleep_s2;
        logic dout;
        logic dout_oe;
        logic overflow_tgl;
    } swa_link_t;
    swa_link_t l;
    swa_link_t next_l;
    logic fifo_in_ready;
    logic link_indiv;
    logic mode_rise;
    always_comb begin
        next_l = l;
        next_l.mode_sync = {l.mode_sync[0], mode};
        next_l.sleep_s1 = sleep_n;
        next_l.sleep_s2 = l.sleep_s1;
        next_l.mode_prev = l.mode_sync[1];
        mode_rise = l.mode_sync[1] && !l.mode_prev;
        link_indiv = l.mode_sync[1] && l.sleep_s2;
        if (mode_rise) begin
            next_l.shreg = SWA_ZERO;
        end else if (link_indiv) begin
            next_l.shreg = {l.shreg[30:0], serial_in_or_bank_select};
            if (!fifo_in_ready) begin
                next_l.overflow_tgl = !l.overflow_tgl;
            end
        end
        next_l.dout = next_l.shreg[SWA_LAST];
        next_l.dout_oe = link_indiv;
    end
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // Each new shift register image crosses by toggle handshake into the single-clock, count-based FIFO.
    // The FIFO sits in the system domain; a toggle handshake carries the word over.
    typedef struct packed {
        logic [31:0] word;
        logic tgl;
    } swa_xfer_t;
    swa_xfer_t x;
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            x <= '0;
        end else if (link_indiv || mode_rise) begin
            x.word <= next_l.shreg;
            x.tgl <= !x.tgl;
        end
    end

    // System domain state.
    typedef struct packed {
        logic [2:0] tgl_sync;
        logic [31:0] word_cap;
        logic word_valid;
        logic [31:0] shadow;
        logic [31:0] latch;
        logic [1:0] mode_s;
        logic [1:0] sleep_s;
        logic [1:0] strobe_s;
        logic [1:0] sel_s;
        logic [1:0] wipe_s;
        logic [1:0] dout_s;
        logic [1:0] oe_s;
        logic [2:0] ovf_s;
        logic [31:0] sw;
        logic sout;
        logic sout_oe;
        logic ovf;
        swa_mode_t state;
    } swa_sys_t;
    swa_sys_t s;
    swa_sys_t next_s;
    logic [31:0] fifo_out;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [31:0] view;
    always_comb begin
        next_s = s;
        fifo_pop = 1'b0;
        view = s.shadow;
        if (ce) begin
            next_s.tgl_sync = {s.tgl_sync[1:0], x.tgl};
            next_s.word_valid = s.tgl_sync[2] != s.tgl_sync[1];
            if (s.tgl_sync[2] != s.tgl_sync[1]) begin
                next_s.word_cap = x.word;
            end
            next_s.mode_s = {s.mode_s[0], mode};
            next_s.sleep_s = {s.sleep_s[0], sleep_n};
            next_s.strobe_s = {s.strobe_s[0], latch_strobe_or_bank_enable};
            next_s.sel_s = {s.sel_s[0], serial_in_or_bank_select};
            next_s.wipe_s = {s.wipe_s[0], latch_wipe};
            next_s.dout_s = {s.dout_s[0], l.dout};
            next_s.oe_s = {s.oe_s[0], l.dout_oe};
            next_s.ovf_s = {s.ovf_s[1:0], l.overflow_tgl};
            if (s.ovf_s[2] != s.ovf_s[1]) begin
                next_s.ovf = 1'b1;
            end
            fifo_pop = fifo_out_valid;
            if (fifo_out_valid) begin
                next_s.shadow = fifo_out;
                view = fifo_out;
            end
            if (!s.sleep_s[1]) begin
                next_s.state = SWA_SLEEP;
            end else if (s.mode_s[1]) begin
                next_s.state = SWA_INDIV;
            end else begin
                next_s.state = SWA_BANK;
            end
            case (s.state)
                SWA_SLEEP: begin
                    next_s.sw = SWA_ZERO;
                end
                SWA_INDIV: begin
                    if (s.wipe_s[1]) begin
                        next_s.latch = SWA_ZERO;
                    end else if (!s.strobe_s[1]) begin
                        next_s.latch = view;
                    end
                    // Strobe high keeps the latch as frozen at its rising edge.
                    next_s.sw = next_s.latch;
                end
                SWA_BANK: begin
                    if (!s.strobe_s[1]) begin
                        next_s.sw = SWA_ZERO;
                    end else if (s.sel_s[1]) begin
                        next_s.sw = SWA_EVEN;
                    end else begin
                        next_s.sw = SWA_ODD;
                    end
                end
                default: begin
                    next_s.sw = SWA_ZERO;
                end
            endcase
            next_s.sout = s.dout_s[1] && (s.state == SWA_INDIV);
            // The enable follows the mode state alone, so it settles while the link clock is idle.
            next_s.sout_oe = (s.state == SWA_INDIV);
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    swa_fifo #(
        .WIDTH(SWA_FIFO_WIDTH),
        .DEPTH(SWA_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .in_data(s.word_cap),
        .in_valid(s.word_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );

    assign switch_on = s.sw;
    assign serial_out = s.sout;
    assign serial_out_oe = s.sout_oe;
    assign fifo_overflow = s.ovf;
endmodule : swa_ctrl

// ===== rtl/swa_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock domain and active-low asynchronous reset.
`timescale 1ns/1ps
module swa_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } swa_fifo_t;
    swa_fifo_t s;
    swa_fifo_t next_s;
    logic push;
    logic pop;
    always_comb begin
        next_s = s;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (ce) begin
            if (push) begin
                next_s.mem[s.wr] = in_data;
                next_s.wr = s.wr + 1'b1;
            end
            if (pop) begin
                next_s.rd = s.rd + 1'b1;
            end
            next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign in_ready = ce && (s.count != (AW+1)'(DEPTH));
    assign out_valid = ce && (s.count != '0);
    assign out_data = s.mem[s.rd];
endmodule : swa_fifo

// ===== rtl/swa_pkg.sv
// Package for the switch array serial latch control block.
// Assumes a 200 MHz system clock and a separate serial link clock.
package swa_pkg;
    localparam int SWA_CHANNELS = 32;
    localparam int SWA_LAST = 31;
    localparam int SWA_FIFO_WIDTH = 32;
    localparam int SWA_FIFO_DEPTH = 16;
    localparam logic [31:0] SWA_ZERO = 32'h00000000;
    localparam logic [31:0] SWA_EVEN = 32'h55555555;
    localparam logic [31:0] SWA_ODD = 32'haaaaaaaa;
    typedef enum logic [1:0] {
        SWA_SLEEP = 2'b00,
        SWA_BANK = 2'b01,
        SWA_INDIV = 2'b11
    } swa_mode_t;
endpackage : swa_pkg

// ===== testbench/swa_ctrl_asserts.sv
// Checker for the switch outputs against the pin levels.
// Assumes pins are held for several clk cycles before being judged.
`timescale 1ns/1ps
module swa_ctrl_asserts
    import swa_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic sleep_n,
    input wire logic mode,
    input wire logic serial_in_or_bank_select,
    input wire logic latch_strobe_or_bank_enable,
    input wire logic latch_wipe,
    input wire logic [31:0] switch_on,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic run;
    logic en;
    logic sel;
    assign run = ce && sleep_n;
    assign en = latch_strobe_or_bank_enable;
    assign sel = serial_in_or_bank_select;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_sleep_off: assert property (ce && !sleep_n [*5] |-> switch_on == SWA_ZERO)
        else $error("switch on in standby");
    a_wipe_off: assert property (run && mode && latch_wipe [*5] |-> switch_on == SWA_ZERO)
        else $error("switch on during wipe");
    a_bank_even: assert property (run && !mode && en && sel [*5] |-> switch_on == SWA_EVEN)
        else $error("even bank wrong");
    a_bank_odd: assert property (run && !mode && en && !sel [*5] |-> switch_on == SWA_ODD)
        else $error("odd bank wrong");
    a_bank_off: assert property (run && !mode && !en [*5] |-> switch_on == SWA_ZERO)
        else $error("disabled bank not off");
    a_out_float: assert property (ce && !(mode && sleep_n) [*5] |-> !serial_out_oe && !serial_out)
        else $error("serial out driven");
    a_out_drive: assert property (run && mode [*5] |-> serial_out_oe)
        else $error("serial out not driven");
    a_latch_hold: assert property (run && mode && en && !latch_wipe [*8] |-> $stable(switch_on))
        else $error("latched switches moved");
endmodule : swa_ctrl_asserts
bind swa_ctrl swa_ctrl_asserts u_chk (
    .clk(clk), .nrst(nrst), .ce(ce), .sleep_n(sleep_n), .mode(mode),
    .serial_in_or_bank_select(serial_in_or_bank_select),
    .latch_strobe_or_bank_enable(latch_strobe_or_bank_enable),
    .latch_wipe(latch_wipe), .switch_on(switch_on), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe)
);

// ===== testbench/swa_ctrl_tb.sv
// Testbench for the switch array control: latching, wipe, bank and standby.
// Assumes the controller model drives the link clock and data pin.
`timescale 1ns/1ps
module swa_ctrl_tb;
    import swa_pkg::*;
    localparam logic [31:0] W1 = 32'hc35a0f96;
    localparam logic [31:0] W2 = 32'h3ca5f069;
    logic clk = 1'b0;
    logic nrst, slp_n, mode, stb, wipe, lclk, sd, so, oe, ovf, ce;
    logic [31:0] sw;
    int fail_count = 0;
    int checked = 0;
    always #2.5 clk = ~clk;
    swa_link_model lnk (.link_clk(lclk), .sdata(sd));
    swa_ctrl uut (
        .clk(clk), .nrst(nrst), .ce(ce), .link_clk(lclk), .sleep_n(slp_n), .mode(mode),
        .serial_in_or_bank_select(sd), .latch_strobe_or_bank_enable(stb),
        .latch_wipe(wipe), .switch_on(sw), .serial_out(so), .serial_out_oe(oe),
        .fifo_overflow(ovf)
    );
    task automatic stop_test;
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    task automatic wt(input logic [31:0] exp);
        for (int i = 0; i < 80 && sw !== exp; i++)
            @(negedge clk);
        chk(sw, exp);
    endtask : wt
    task automatic t_sleep;
        idle(25);
        chk(sw, SWA_ZERO);
        chk({31'h0, oe}, 32'h0);
        slp_n = 1'b1;
        mode = 1'b1;
        stb = 1'b1;
        idle(4);
        lnk.ticks(3);
    endtask : t_sleep
    task automatic t_load;
        lnk.send(W1);
        idle(20);
        chk(sw, SWA_ZERO);
        chk({31'h0, so}, {31'h0, W1[31]});
        stb = 1'b0;
        wt(W1);
        stb = 1'b1;
        lnk.send(W2);
        idle(20);
        chk(sw, W1);
        stb = 1'b0;
        wt(W2);
        lnk.send(W1);
        wt(W1);
        stb = 1'b1;
    endtask : t_load
    task automatic t_wipe;
        wipe = 1'b1;
        stb = 1'b0;
        wt(SWA_ZERO);
        idle(20);
        chk(sw, SWA_ZERO);
        wipe = 1'b0;
        wt(W1);
        stb = 1'b1;
    endtask : t_wipe
    task automatic t_bank;
        mode = 1'b0;
        wipe = 1'b1;
        for (int i = 0; i < 3; i++) begin
            stb = (i != 2);
            lnk.level(i == 0);
            wt(i == 2 ? SWA_ZERO : (i == 0 ? SWA_EVEN : SWA_ODD));
        end
        stb = 1'b1;
        lnk.level(1'b1);
        lnk.ticks(4);
        idle(10);
        chk(sw, SWA_EVEN);
        chk({31'h0, oe}, 32'h0);
        wipe = 1'b0;
    endtask : t_bank
    task automatic t_mode;
        lnk.level(1'b0);
        mode = 1'b1;
        idle(4);
        lnk.ticks(3);
        stb = 1'b0;
        idle(30);
        chk(sw, SWA_ZERO);
        lnk.send(W2);
        wt(W2);
        stb = 1'b1;
        idle(10);
        slp_n = 1'b0;
        wt(SWA_ZERO);
        lnk.send(W1);
        slp_n = 1'b1;
        idle(30);
        chk(sw, W2);
        chk({31'h0, ovf}, 32'h0);
        ce = 1'b0;
        wipe = 1'b1;
        idle(20);
        chk(sw, W2);
        ce = 1'b1;
        wt(SWA_ZERO);
        wipe = 1'b0;
    endtask : t_mode
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        slp_n = 1'b0;
        mode = 1'b0;
        stb = 1'b0;
        wipe = 1'b0;
        fork
            lnk.ticks(4);
        join_none
        idle(6);
        nrst = 1'b1;
        t_sleep();
        t_load();
        t_wipe();
        t_bank();
        t_mode();
        stop_test();
    end
endmodule : swa_ctrl_tb

// ===== testbench/swa_link_model.sv
// Controller model that shifts words on its own link clock.
// Assumes the bench calls its tasks; the clock stands still between frames.
`timescale 1ns/1ps
module swa_link_model (
    output logic link_clk,
    output logic sdata
);
    initial begin
        link_clk = 1'b0;
        sdata = 1'b0;
    end
    task automatic ticks(input int n);
        repeat (n) begin
            #16.3 link_clk = 1'b1;
            #13.7 link_clk = 1'b0;
        end
    endtask : ticks
    task automatic level(input logic b);
        sdata = b;
    endtask : level
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            sdata = w[i];
            ticks(1);
        end
        sdata = ~sdata;
    endtask : send
endmodule : swa_link_model
